// ---- hdl/scpl_cmd_decode.v ----
// Command byte capture and decode for the three-wire link
`timescale 1ns/1ps
`include "scpl_regs.vh"

module scpl_cmd_decode
(
	input  wire       clock_in,      // System clock
	input  wire       arst_n_in,     // Asynchronous reset, active low
	input  wire       enable_in,     // Inputs accepted when high
	input  wire       select_in,     // Synchronised serial select
	input  wire       sclk_in,       // Synchronised serial clock
	input  wire       sdata_in,      // Synchronised serial data
	output reg        cmd_valid_out, // One-cycle pulse, byte complete
	output reg  [6:0] cmd_addr_out,  // Register address
	output reg        cmd_write_out  // High for write, low for read
);

	reg                       sclk_prev_reg;
	reg [`SCPL_CMD_CNT_W-1:0] bit_cnt_reg;
	reg [`SCPL_CMD_BITS-1:0]  shift_reg;
	wire                      sclk_rise;
	wire [`SCPL_CMD_BITS-1:0] shift_next;

	assign sclk_rise  = sclk_in & ~sclk_prev_reg;
	assign shift_next = {sdata_in, shift_reg[`SCPL_CMD_BITS-1:1]};

	// ****************************************************************
	// Shift in the first byte of a transaction, low bit first
	// ****************************************************************
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sclk_prev_reg <= 1'h0;
			bit_cnt_reg   <= {`SCPL_CMD_CNT_W{1'b0}};
			shift_reg     <= {`SCPL_CMD_BITS{1'b0}};
			cmd_valid_out <= 1'h0;
			cmd_addr_out  <= 7'h00;
			cmd_write_out <= 1'h0;
		end
		else
		begin
			sclk_prev_reg <= sclk_in;
			cmd_valid_out <= 1'h0;
			// Select low or inputs disabled: next byte is a command
			if (!select_in || !enable_in)
				bit_cnt_reg <= {`SCPL_CMD_CNT_W{1'b0}}; // RL14
			else if (sclk_rise &&
				bit_cnt_reg < `SCPL_CMD_BITS)
			begin
				shift_reg   <= shift_next;
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
				if (bit_cnt_reg == `SCPL_CMD_BITS - 1)
				begin
					cmd_valid_out <= 1'h1; // RL14
					cmd_addr_out  <= shift_next[`SCPL_CMD_ADDR_MSB:
						`SCPL_CMD_ADDR_LSB]; // RL15
					cmd_write_out <= (shift_next[`SCPL_CMD_RW_BIT] ==
						`SCPL_CMD_WRITE); // RL16
				end
			end
		end
	end

endmodule

// ---- hdl/scpl_pin_logic.v ----
// Pin logic of the system controller: reset, watchdog, irq, SRAM, command
//
// Notes on behaviour
// RL1 - Host holds RAM enable low to access SRAM; high keeps both enables off.
// RL2 - Active-low enable output selects the low-byte SRAM.
// RL3 - Active-low enable output selects the high-byte SRAM.
// RL4 - High-byte enable asserts only when high select and RAM enable are low.
// RL5 - Low-byte enable asserts only when low select and RAM enable low.
// RL6 - Interrupt is high while flag and its enable both stay set.
// RL7 - Reset driven low on supply fault, watchdog, power-up hold, pushbutton.
// RL8 - External low on reset is debounced, then a 250ms pulse follows.
// RL9 - Reset pin only ever pulled low, otherwise released.
// RL10 - Host strobes low each watchdog period, else reset is driven.
// RL11 - All timing derives from the 32.768kHz crystal; the release blanking counts system clock cycles.
// RL12 - After supply rises, all inputs ignored for 250ms; here the alarm flag and irq enable still drive the interrupt.
// RL13 - Supply back in tolerance holds reset for 250ms.
// RL14 - First byte of each transaction is the command byte.
// RL15 - Command bits six to zero give the register address.
// RL16 - Command bit seven: zero reads, one writes.
// RL17 - Host holds serial select high for the whole transaction.
// RL18 - Below power-fail level, both SRAM enables forced inactive.
// RL19 - Alarm flag reaches the interrupt only when its enable is set.
// RL20 - Watchdog restarts on each synchronised low strobe level.
// RL21 - Reset input synchronised before debounce; own drive ignored.
`timescale 1ns/1ps
`include "scpl_regs.vh"

module scpl_pin_logic
#(
	parameter [`SCPL_TICK_W-1:0] HOLD_TICKS =
		(`SCPL_HOLD_TIME_MS * `SCPL_XTAL_HZ + 999) / 1000,
	parameter [`SCPL_TICK_W-1:0] WDOG_TICKS =
		(`SCPL_WDOG_TIME_MS * `SCPL_XTAL_HZ) / 1000,
	parameter [`SCPL_TICK_W-1:0] DEBOUNCE_TICKS =
		(`SCPL_DEBOUNCE_TIME_MS * `SCPL_XTAL_HZ + 999) / 1000
)
(
	input  wire       clock_in,                  // System clock, 100 MHz
	input  wire       arst_n_in,                 // Async reset, active low
	input  wire       crystal_in,                // 32.768kHz oscillator
	output wire       crystal_out,               // Oscillator feedback
	input  wire       supply_fail_trip_level_in, // High: supply above trip
	input  wire       power_fail_level_in,       // High: below power-fail
	input  wire       ram_enable_in_n_in,        // RAM enable, active low
	input  wire       high_byte_select_n_in,     // High byte, active low
	input  wire       low_byte_select_n_in,      // Low byte, active low
	output wire       sram_low_byte_enable_n_out,  // Low SRAM enable
	output wire       sram_high_byte_enable_n_out, // High SRAM enable
	input  wire       alarm_match_flag_in,       // Alarm status flag
	input  wire       alarm_irq_enable_in,       // Alarm irq enable bit
	output wire       irq_out,                   // Interrupt, active high
	input  wire       watchdog_strobe_n_in,      // Strobe, active low
	input  wire       cpu_reset_n_in,            // Reset pin level
	output wire       cpu_reset_n_out,           // Reset pin drive value
	output wire       cpu_reset_n_oe_out,        // Reset pin drive enable
	input  wire       serial_select_in,          // Serial select
	input  wire       serial_clock_in,           // Serial clock
	input  wire       serial_data_in,            // Serial data
	output wire       cmd_valid_out,             // Command byte pulse
	output wire [6:0] cmd_addr_out,              // Command address
	output wire       cmd_write_out,             // Command direction
	output wire       inputs_live_out            // Inputs accepted
);

	// ****************************************************************
	// Local constants
	// ****************************************************************
	localparam [`SCPL_BLANK_W-1:0] BLANK_CYCLES =
		(`SCPL_RELEASE_BLANK_NS + `SCPL_CLK_PERIOD_NS - 1) /
		`SCPL_CLK_PERIOD_NS;
	localparam [`SCPL_TICK_W-1:0] TICK_ZERO = {`SCPL_TICK_W{1'b0}};
	localparam [`SCPL_TICK_W-1:0] TICK_ONE  = {{(`SCPL_TICK_W-1){1'b0}},
		1'b1};
	// Idle levels: strobe, reset pin and byte selects high, link lines low
	localparam [`SCPL_SYNC_W-1:0] SYNC_RESET = 11'h0F8;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	wire [`SCPL_SYNC_W-1:0]  pins_s;
	wire                     xtal_s;
	wire                     vcc_ok_s;
	wire                     vcc_pf_s;
	wire                     ram_en_n_s;
	wire                     hbs_n_s;
	wire                     lbs_n_s;
	wire                     strobe_n_s;
	wire                     rst_pin_s;
	wire                     tick;
	wire                     vcc_bad;
	wire                     hold_busy;
	wire                     inputs_live;
	wire                     sram_access;
	wire                     pb_press;
	wire                     wdog_expire;
	reg                      xtal_prev_reg;
	reg                      crystal_out_reg;
	reg                      powering_up_reg;
	reg                      powering_up_next;
	reg  [`SCPL_TICK_W-1:0]  hold_cnt_reg;
	reg  [`SCPL_TICK_W-1:0]  hold_cnt_next;
	reg  [`SCPL_TICK_W-1:0]  wdog_cnt_reg;
	reg  [`SCPL_TICK_W-1:0]  wdog_cnt_next;
	reg  [`SCPL_TICK_W-1:0]  deb_cnt_reg;
	reg  [`SCPL_TICK_W-1:0]  deb_cnt_next;
	reg  [`SCPL_BLANK_W-1:0] blank_cnt_reg;
	reg  [`SCPL_BLANK_W-1:0] blank_cnt_next;
	reg                      drive_reg;
	reg                      irq_reg;
	reg                      lo_en_n_reg;
	reg                      hi_en_n_reg;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	scpl_sync
	#(
		.WIDTH       (`SCPL_SYNC_W),
		.RESET_VALUE (SYNC_RESET)
	)
	u_sync
	(
		.clock_in  (clock_in),
		.arst_n_in (arst_n_in),
		.async_in  ({serial_data_in, serial_clock_in, serial_select_in,
			cpu_reset_n_in, watchdog_strobe_n_in, low_byte_select_n_in,
			high_byte_select_n_in, ram_enable_in_n_in,
			power_fail_level_in, supply_fail_trip_level_in,
			crystal_in}),
		.sync_out  (pins_s)
	);

	// Named views of the synchronised pins
	assign xtal_s     = pins_s[`SCPL_S_XTAL];
	assign vcc_ok_s   = pins_s[`SCPL_S_VCC_OK];
	assign vcc_pf_s   = pins_s[`SCPL_S_VCC_PF];
	assign ram_en_n_s = pins_s[`SCPL_S_RAM_EN];
	assign hbs_n_s    = pins_s[`SCPL_S_HBS];
	assign lbs_n_s    = pins_s[`SCPL_S_LBS];
	assign strobe_n_s = pins_s[`SCPL_S_STROBE];
	assign rst_pin_s  = pins_s[`SCPL_S_RST]; // RL21

	// ****************************************************************
	// Crystal timebase
	// ****************************************************************
	// One tick per rising crystal edge; hold, watchdog and debounce timers count ticks
	assign tick = xtal_s & ~xtal_prev_reg; // RL11

	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			xtal_prev_reg   <= 1'h0;
			crystal_out_reg <= 1'h1;
		end
		else
		begin
			xtal_prev_reg   <= xtal_s;
			crystal_out_reg <= ~xtal_s;
		end
	end

	assign crystal_out = crystal_out_reg;

	// ****************************************************************
	// Supply state and reset reasons
	// ****************************************************************
	assign vcc_bad     = ~vcc_ok_s;
	assign hold_busy   = (hold_cnt_reg != TICK_ZERO);
	assign inputs_live = ~powering_up_reg & ~vcc_bad; // RL12
	assign sram_access = inputs_live & ~vcc_pf_s; // RL18

	// Pushbutton: own drive and its release tail are blanked
	assign pb_press = inputs_live & ~drive_reg & ~rst_pin_s & tick &
		(blank_cnt_reg == {`SCPL_BLANK_W{1'b0}}) &
		(deb_cnt_reg == DEBOUNCE_TICKS - TICK_ONE); // RL21

	// Watchdog runs out without a low strobe
	assign wdog_expire = inputs_live & ~hold_busy & tick &
		(wdog_cnt_reg == WDOG_TICKS - TICK_ONE); // RL10

	// Next values of the hold timer and power-up flag
	always @*
	begin
		hold_cnt_next    = hold_cnt_reg;
		powering_up_next = powering_up_reg;
		if (vcc_bad)
		begin
			hold_cnt_next    = HOLD_TICKS; // RL13
			powering_up_next = 1'h1; // RL12
		end
		else if (wdog_expire || pb_press)
			hold_cnt_next = HOLD_TICKS; // RL8
		else if (hold_busy && tick)
			hold_cnt_next = hold_cnt_reg - TICK_ONE;
		else if (!hold_busy)
			powering_up_next = 1'h0;
	end

	// Debounce counts ticks of a steady low from outside
	always @*
	begin
		deb_cnt_next = deb_cnt_reg;
		if (!inputs_live || drive_reg || rst_pin_s ||
			blank_cnt_reg != {`SCPL_BLANK_W{1'b0}})
			deb_cnt_next = TICK_ZERO; // RL21
		else if (tick && deb_cnt_reg < DEBOUNCE_TICKS - TICK_ONE)
			deb_cnt_next = deb_cnt_reg + TICK_ONE; // RL8
	end

	// Blanking while the pin rises back after our own drive
	always @*
	begin
		blank_cnt_next = blank_cnt_reg;
		if (drive_reg)
			blank_cnt_next = BLANK_CYCLES; // RL21
		else if (blank_cnt_reg != {`SCPL_BLANK_W{1'b0}})
			blank_cnt_next = blank_cnt_reg - {{(`SCPL_BLANK_W-1){1'b0}},
				1'b1};
	end

	// Watchdog restarts on any low strobe level
	always @*
	begin
		wdog_cnt_next = wdog_cnt_reg;
		if (!inputs_live || hold_busy || !strobe_n_s)
			wdog_cnt_next = TICK_ZERO; // RL20
		else if (tick)
			wdog_cnt_next = wdog_cnt_reg + TICK_ONE; // RL10
	end

	// ****************************************************************
	// Timer and reset drive registers
	// ****************************************************************
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			hold_cnt_reg    <= HOLD_TICKS;
			powering_up_reg <= 1'h1;
			wdog_cnt_reg    <= {`SCPL_TICK_W{1'b0}};
			deb_cnt_reg     <= {`SCPL_TICK_W{1'b0}};
			blank_cnt_reg   <= {`SCPL_BLANK_W{1'b0}};
			drive_reg       <= 1'h1;
		end
		else
		begin
			hold_cnt_reg    <= hold_cnt_next;
			powering_up_reg <= powering_up_next;
			wdog_cnt_reg    <= wdog_cnt_next;
			deb_cnt_reg     <= deb_cnt_next;
			blank_cnt_reg   <= blank_cnt_next;
			drive_reg       <= vcc_bad | (hold_cnt_next != TICK_ZERO); // RL7
		end
	end

	// Open drain: value always low, only the enable moves
	assign cpu_reset_n_out    = 1'h0; // RL9
	assign cpu_reset_n_oe_out = drive_reg; // RL9

	// ****************************************************************
	// Interrupt output
	// ****************************************************************
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			irq_reg <= 1'h0;
		else
			irq_reg <= alarm_match_flag_in & alarm_irq_enable_in; // RL6 RL19
	end

	assign irq_out = irq_reg;

	// ****************************************************************
	// SRAM chip enable gating
	// ****************************************************************
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			lo_en_n_reg <= 1'h1;
			hi_en_n_reg <= 1'h1;
		end
		else
		begin
			lo_en_n_reg <= ~(sram_access & ~ram_en_n_s & ~lbs_n_s); // RL5 RL1
			hi_en_n_reg <= ~(sram_access & ~ram_en_n_s & ~hbs_n_s); // RL4 RL1
		end
	end

	assign sram_low_byte_enable_n_out  = lo_en_n_reg; // RL2
	assign sram_high_byte_enable_n_out = hi_en_n_reg; // RL3

	// ****************************************************************
	// Command byte decoder
	// ****************************************************************
	scpl_cmd_decode u_cmd
	(
		.clock_in      (clock_in),
		.arst_n_in     (arst_n_in),
		.enable_in     (inputs_live),
		.select_in     (pins_s[`SCPL_S_CS]),
		.sclk_in       (pins_s[`SCPL_S_SCLK]),
		.sdata_in      (pins_s[`SCPL_S_SDATA]),
		.cmd_valid_out (cmd_valid_out),
		.cmd_addr_out  (cmd_addr_out),
		.cmd_write_out (cmd_write_out)
	);

	assign inputs_live_out = inputs_live;

endmodule

// ---- hdl/scpl_regs.vh ----
// Constants of the system controller pin logic
`ifndef SCPL_REGS_VH
`define SCPL_REGS_VH

// ****************************************************************
// Clock and timebase
// ****************************************************************
`define SCPL_CLK_HZ            100000000
`define SCPL_CLK_PERIOD_NS     10
`define SCPL_XTAL_HZ           32768
`define SCPL_TICK_W            16

// ****************************************************************
// Times in their own units
// ****************************************************************
`define SCPL_HOLD_TIME_MS      250
`define SCPL_WDOG_TIME_MS      1500
`define SCPL_DEBOUNCE_TIME_MS  10
`define SCPL_RELEASE_BLANK_NS  100
`define SCPL_BLANK_W           8

// ****************************************************************
// Command byte layout
// ****************************************************************
`define SCPL_CMD_BITS          8
`define SCPL_CMD_CNT_W         4
`define SCPL_CMD_ADDR_MSB      6
`define SCPL_CMD_ADDR_LSB      0
`define SCPL_CMD_RW_BIT        7
`define SCPL_CMD_WRITE         1'h1

// ****************************************************************
// Synchroniser bit positions
// ****************************************************************
`define SCPL_SYNC_W            11
`define SCPL_S_XTAL            0
`define SCPL_S_VCC_OK          1
`define SCPL_S_VCC_PF          2
`define SCPL_S_RAM_EN          3
`define SCPL_S_HBS             4
`define SCPL_S_LBS             5
`define SCPL_S_STROBE          6
`define SCPL_S_RST             7
`define SCPL_S_CS              8
`define SCPL_S_SCLK            9
`define SCPL_S_SDATA           10

`endif

// ---- hdl/scpl_sync.v ----
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module scpl_sync
#(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
	input  wire             clock_in,  // System clock
	input  wire             arst_n_in, // Asynchronous reset, active low
	input  wire [WIDTH-1:0] async_in,  // Pins from outside the domain
	output wire [WIDTH-1:0] sync_out   // Synchronised levels
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// ****************************************************************
	// Two stages; only the second stage is read
	// ****************************************************************
	always @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			meta_reg <= RESET_VALUE;
			sync_reg <= RESET_VALUE;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule

// ---- testbench/scpl_host_model.sv ----
// Host side of the three-wire link
`timescale 1ns/1ps

module scpl_host_model
(
	input  wire       clock_in,   // System clock
	input  wire       send_in,    // Start one frame
	input  wire [7:0] byte_in,    // Command byte
	output reg        select_out, // Serial select
	output reg        sclk_out,   // Serial clock, 80 ns
	output reg        data_out,   // Serial data
	output reg        done_out    // Frame finished
);
	integer i;

	initial
	begin
		select_out = 1'b0;
		sclk_out   = 1'b0;
		data_out   = 1'b1;
		done_out   = 1'b0;
	end

	// One frame per request, clock stands still outside frames
	always @(posedge clock_in)
		if (send_in && !done_out)
		begin
			select_out <= 1'b1;
			for (i = 0; i < 8; i = i + 1)
			begin
				data_out <= byte_in[i];
				repeat (4) @(posedge clock_in);
				sclk_out <= 1'b1;
				repeat (4) @(posedge clock_in);
				sclk_out <= 1'b0;
			end
			repeat (4) @(posedge clock_in);
			select_out <= 1'b0;
			data_out   <= ~data_out; // Released line shows no stale bit
			done_out   <= 1'b1;
			wait (!send_in);
			@(posedge clock_in);
			done_out <= 1'b0;
		end
endmodule

// ---- testbench/scpl_pin_logic_asserts.sv ----
// Concurrent checks on the pin logic ports
`timescale 1ns/1ps

module scpl_pin_logic_asserts
#(
	parameter [15:0] HOLD_TICKS = 16'h2000
)
(
	input logic clock_in,                    // System clock
	input logic arst_n_in,                   // Async reset, active low
	input logic crystal_in,                  // Timebase
	input logic crystal_out,                 // Oscillator feedback
	input logic supply_fail_trip_level_in,   // Supply good
	input logic power_fail_level_in,         // Below power-fail
	input logic ram_enable_in_n_in,          // RAM enable
	input logic high_byte_select_n_in,       // High select
	input logic low_byte_select_n_in,        // Low select
	input logic sram_low_byte_enable_n_out,  // Low enable
	input logic sram_high_byte_enable_n_out, // High enable
	input logic alarm_match_flag_in,         // Alarm flag
	input logic alarm_irq_enable_in,         // Alarm enable
	input logic irq_out,                     // Interrupt
	input logic cpu_reset_n_out,             // Reset drive value
	input logic cpu_reset_n_oe_out,          // Reset drive enable
	input logic cmd_valid_out,               // Command pulse
	input logic inputs_live_out              // Inputs accepted
);
	// ************************************************
	// Tick counter over each reset pulse
	// ************************************************
	logic [2:0]  xs_reg;
	logic [15:0] hold_cnt_reg;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);

	// Counts timebase ticks while the reset pin is driven
	always @(posedge clock_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			xs_reg       <= 3'h0;
			hold_cnt_reg <= 16'h0000;
		end
		else
		begin
			xs_reg <= {xs_reg[1:0], crystal_in};
			if (!cpu_reset_n_oe_out)
				hold_cnt_reg <= 16'h0000;
			else if (xs_reg[1] && !xs_reg[2])
				hold_cnt_reg <= hold_cnt_reg + 16'h0001;
		end

	// A command pulse lasts one cycle
	sequence cmd_pulse_s;
		cmd_valid_out ##1 !cmd_valid_out;
	endsequence

	sram_low_a: assert property (!sram_low_byte_enable_n_out |->
		!$past(ram_enable_in_n_in, 3) && !$past(low_byte_select_n_in, 3))
		else $error("low enable without request");
	sram_high_a: assert property (!sram_high_byte_enable_n_out |->
		!$past(ram_enable_in_n_in, 3) && !$past(high_byte_select_n_in, 3))
		else $error("high enable without request");
	pf_block_a: assert property (power_fail_level_in [*4] |=>
		sram_low_byte_enable_n_out && sram_high_byte_enable_n_out)
		else $error("enable active in power fail");
	irq_set_a: assert property (alarm_match_flag_in &&
		alarm_irq_enable_in |=> irq_out)
		else $error("irq not raised");
	irq_clr_a: assert property (!(alarm_match_flag_in &&
		alarm_irq_enable_in) |=> !irq_out)
		else $error("irq raised without cause");
	rst_drive_a: assert property (cpu_reset_n_out == 1'b0)
		else $error("reset pin driven high");
	hold_len_a: assert property ($fell(cpu_reset_n_oe_out) |->
		hold_cnt_reg >= HOLD_TICKS - 16'h0001)
		else $error("reset pulse too short");
	supply_rst_a: assert property (!supply_fail_trip_level_in [*4] |=>
		cpu_reset_n_oe_out && !inputs_live_out)
		else $error("no reset on supply fault");
	cmd_pulse_a: assert property (cmd_valid_out |-> cmd_pulse_s)
		else $error("command pulse too long");
	xtal_fb_a: assert property (crystal_out == !$past(crystal_in, 3))
		else $error("oscillator feedback wrong");
endmodule

bind scpl_pin_logic scpl_pin_logic_asserts #(.HOLD_TICKS(HOLD_TICKS))
	scpl_pin_logic_asserts_i (.clock_in, .arst_n_in, .crystal_in,
	.supply_fail_trip_level_in, .power_fail_level_in, .ram_enable_in_n_in,
	.high_byte_select_n_in, .low_byte_select_n_in,
	.sram_low_byte_enable_n_out, .sram_high_byte_enable_n_out,
	.alarm_match_flag_in, .alarm_irq_enable_in, .irq_out, .cpu_reset_n_out,
	.cpu_reset_n_oe_out, .cmd_valid_out, .inputs_live_out, .crystal_out);

// ---- testbench/scpl_pin_logic_tb_top.sv ----
// Testbench for the system controller pin logic
`timescale 1ns/1ps

module scpl_pin_logic_tb_top;
	localparam [15:0] HOLD = 16'h0008;
	localparam [15:0] WDOG = 16'h0014;
	localparam [15:0] DEB  = 16'h0003;
	logic       clk, rst_n, xtal, sup_ok, pf, ram_n, hbs_n, lbs_n;
	logic       flag, en, stb_n, pb_n, send, done, sel, sclk, sdat;
	logic       enl_n, enh_n, irq, rst_drv, oe, vld, wr, live;
	logic [7:0] hbyte;
	logic [6:0] addr;
	logic [8:0] rows [8];
	int         mismatches, checks, nvalid, i;
	wire        rst_wire = (oe ? rst_drv : 1'b1) & pb_n; // Pull-up pin

	scpl_pin_logic #(.HOLD_TICKS(HOLD), .WDOG_TICKS(WDOG),
		.DEBOUNCE_TICKS(DEB)) scpl_pin_logic_i (
		.clock_in(clk), .arst_n_in(rst_n), .crystal_in(xtal),
		.crystal_out(), .supply_fail_trip_level_in(sup_ok),
		.power_fail_level_in(pf), .ram_enable_in_n_in(ram_n),
		.high_byte_select_n_in(hbs_n), .low_byte_select_n_in(lbs_n),
		.sram_low_byte_enable_n_out(enl_n),
		.sram_high_byte_enable_n_out(enh_n),
		.alarm_match_flag_in(flag), .alarm_irq_enable_in(en),
		.irq_out(irq), .watchdog_strobe_n_in(stb_n),
		.cpu_reset_n_in(rst_wire), .cpu_reset_n_out(rst_drv),
		.cpu_reset_n_oe_out(oe), .serial_select_in(sel),
		.serial_clock_in(sclk), .serial_data_in(sdat),
		.cmd_valid_out(vld), .cmd_addr_out(addr),
		.cmd_write_out(wr), .inputs_live_out(live));
	scpl_host_model scpl_host_model_i (.clock_in(clk), .send_in(send),
		.byte_in(hbyte), .select_out(sel), .sclk_out(sclk),
		.data_out(sdat), .done_out(done));

	// ************************************************
	// Clocks, pulse counter and watchdog
	// ************************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		xtal = 1'b0;
		forever #200 xtal = ~xtal;
	end
	always @(posedge clk)
		if (vld === 1'b1)
			nvalid++;
	initial
	begin
		#300000;
		mismatches++;
		test_done;
	end

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task ticks(input int n);
		repeat (n) @(posedge xtal);
		@(posedge clk);
		#1;
	endtask

	task strobe;
		@(posedge clk);
		stb_n <= 1'b0;
		repeat (4) @(posedge clk);
		stb_n <= 1'b1;
	endtask

	task automatic send_cmd(input logic [7:0] b);
		int n;
		n = nvalid;
		@(posedge clk);
		hbyte <= b;
		send  <= 1'b1;
		for (int k = 0; k < 300 && done !== 1'b1; k++)
			@(posedge clk);
		send <= 1'b0;
		repeat (3) @(posedge clk);
		chk("cmd count", 8'h01, 8'(nvalid - n));
		chk("cmd addr", {1'b0, b[6:0]}, {1'b0, addr});
		chk("cmd dir", b[7], wr);
	endtask

	task test_done;
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ************************************************
	// Main sequence
	// ************************************************
	initial
	begin
		rows = '{9'h019, 9'h054, 9'h08A, 9'h0C6, 9'h11F, 9'h186, 9'h036,
			9'h000};
		{rst_n, sup_ok, pf, ram_n, hbs_n, lbs_n} = 6'h17;
		{flag, en, send, pb_n, stb_n} = 5'h03;
		hbyte = 8'h00;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("oe reset", 8'h01, oe);
		ticks(HOLD - 3);
		chk("oe hold", 8'h01, oe);
		chk("live hold", 8'h00, live);
		ticks(5);
		chk("oe done", 8'h00, oe);
		chk("live done", 8'h01, live);
		for (i = 0; i < 8; i++)
		begin
			@(posedge clk);
			{ram_n, hbs_n, lbs_n, pf, flag, en} <= rows[i][8:3];
			repeat (6) @(posedge clk);
			#1;
			chk("low en", rows[i][2], enl_n);
			chk("high en", rows[i][1], enh_n);
			chk("irq", rows[i][0], irq);
		end
		{ram_n, hbs_n, lbs_n} <= 3'h7;
		strobe;
		send_cmd(8'h85);
		send_cmd(8'h2A);
		// Watchdog kept quiet by strobes, then left to expire
		strobe;
		repeat (3)
		begin
			ticks(WDOG / 2);
			strobe;
		end
		chk("wdog fed", 8'h00, oe);
		ticks(WDOG - 5);
		chk("wdog early", 8'h00, oe);
		ticks(7);
		chk("wdog fire", 8'h01, oe);
		ticks(HOLD - 4);
		chk("wdog pulse", 8'h01, oe);
		ticks(6);
		chk("wdog end", 8'h00, oe);
		// Pushbutton held past the debounce time
		strobe;
		pb_n <= 1'b0;
		ticks(DEB + 2);
		pb_n <= 1'b1;
		chk("pb fire", 8'h01, oe);
		ticks(HOLD - 4);
		chk("pb pulse", 8'h01, oe);
		ticks(6);
		chk("pb end", 8'h00, oe);
		// Supply fault while SRAM is requested
		strobe;
		sup_ok <= 1'b0;
		ram_n  <= 1'b0;
		lbs_n  <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("oe supply", 8'h01, oe);
		chk("live supply", 8'h00, live);
		chk("low en supply", 8'h01, enl_n);
		ticks(3);
		sup_ok <= 1'b1;
		ticks(HOLD - 3);
		chk("oe return", 8'h01, oe);
		ticks(6);
		chk("oe released", 8'h00, oe);
		chk("low en live", 8'h00, enl_n);
		test_done;
	end
endmodule
